// ==== verilog/mcd_decoder.v ====
// Multiply, product-register and control instruction decoder
`include "mcd_map.vh"
`default_nettype none

module mcd_decoder (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        clkEn,
  input  wire        instrValid,
  input  wire [15:0] instrWord,
  output wire        instrReady,
  output wire        extWordReq,
  output reg         opValid,
  output reg  [4:0]  opCode,
  output reg         unrecognised,
  output reg         indirectMode,
  output reg  [6:0]  dataAddr,
  output reg  [2:0]  auxRegSel,
  output reg  [15:0] immValue,
  output reg         twoWordOp,
  output reg         clearSum,
  output reg         clearProduct,
  output reg  [1:0]  productShiftField,
  output reg  [3:0]  ctrlBitSel,
  output reg         ctrlBitValue,
  output reg         statusWordOne,
  output reg         useBlockMovePtr,
  output reg         dataMove,
  output reg         lowPowerWait
);

  // ****************************************
  // State
  // ****************************************
  localparam [0:0] ST_FIRST  = 1'b0;
  localparam [0:0] ST_SECOND = 1'b1;

  reg        state_reg;
  reg        state_next;
  reg [15:0] held_reg;
  reg [4:0]  heldOp_reg;

  // Combinational decode of the current first word
  reg [4:0]  decOp;
  reg        decTwo;
  wire [7:0] upper = instrWord[15:8];

  // ****************************************
  // Pattern decode
  // ****************************************
  // Fixed words are checked first so they are not swallowed by byte patterns
  always @* begin
    decOp  = `MCD_OP_NONE;
    decTwo = 1'b0;
    if (instrWord == `MCD_W_ADD_PRODUCT)
      decOp = `MCD_OP_ADD_PRODUCT;
    else if (instrWord == `MCD_W_PRODUCT_TO_SUM)
      decOp = `MCD_OP_PRODUCT_SUM;
    else if (instrWord == `MCD_W_SUB_PRODUCT)
      decOp = `MCD_OP_SUB_PRODUCT;
    else if (instrWord == `MCD_W_ZERO_PRODUCT)
      decOp = `MCD_OP_ZERO_PRODUCT;
    else if (instrWord == `MCD_W_LOW_POWER)
      decOp = `MCD_OP_LOW_POWER;
    else if (instrWord == `MCD_W_MUL_LONG) begin
      decOp  = `MCD_OP_MUL_LONG;
      decTwo = 1'b1;
    end else if (instrWord == `MCD_W_CLEAR_REPEAT) begin
      decOp  = `MCD_OP_CLEAR_REPEAT;
      decTwo = 1'b1;
    end else if (instrWord[15:2] == `MCD_P_SHIFT_MODE)
      decOp = `MCD_OP_SET_SHIFT;
    else if (instrWord[15:4] == `MCD_P_CTRL_BIT)
      decOp = instrWord[0] ? `MCD_OP_SET_CTRL : `MCD_OP_CLEAR_CTRL;
    else if (instrWord[15:13] == `MCD_P_MUL_SHORT)
      decOp = `MCD_OP_MUL_SHORT;
    else begin
      case (upper)
        `MCD_B_LOAD_HIGH_PROD: decOp = `MCD_OP_LOAD_HIGH;
        `MCD_B_LOAD_MULT_ACC:  decOp = `MCD_OP_LOAD_MULT_ACC;
        `MCD_B_LOAD_MULT_MOVE: decOp = `MCD_OP_LOAD_MULT_MV;
        `MCD_B_LOAD_MULT_PROD: decOp = `MCD_OP_LOAD_MULT_PRD;
        `MCD_B_LOAD_MULT_SUB:  decOp = `MCD_OP_LOAD_MULT_SUB;
        `MCD_B_MUL_ACC: begin
          decOp  = `MCD_OP_MUL_ACC;
          decTwo = 1'b1;
        end
        `MCD_B_MUL_ACC_SHIFT: begin
          decOp  = `MCD_OP_MUL_ACC_SHIFT;
          decTwo = 1'b1;
        end
        `MCD_B_MUL_ACC_PTR:    decOp = `MCD_OP_MUL_ACC_PTR;
        `MCD_B_MUL_ACC_PTR_MV: decOp = `MCD_OP_MUL_ACC_PTRMV;
        `MCD_B_MULTIPLY_ADD:   decOp = `MCD_OP_MULTIPLY_ADD;
        `MCD_B_MULTIPLY_SUB:   decOp = `MCD_OP_MULTIPLY_SUB;
        `MCD_B_STORE_HIGH:     decOp = `MCD_OP_STORE_HIGH;
        `MCD_B_STORE_LOW:      decOp = `MCD_OP_STORE_LOW;
        `MCD_B_SQUARE_ADD:     decOp = `MCD_OP_SQUARE_ADD;
        `MCD_B_SQUARE_SUB:     decOp = `MCD_OP_SQUARE_SUB;
        `MCD_B_LOAD_ST0,
        `MCD_B_LOAD_ST1:       decOp = `MCD_OP_LOAD_STATUS;
        `MCD_B_STORE_ST0,
        `MCD_B_STORE_ST1:      decOp = `MCD_OP_STORE_STATUS;
        `MCD_B_REPEAT:         decOp = `MCD_OP_REPEAT;
        default:               decOp = `MCD_OP_NONE;
      endcase
    end
  end

  // ****************************************
  // Handshake
  // ****************************************
  // Fetch side is accepted whenever clkEn is high; a held two-word op waits for its operand
  assign instrReady = clkEn;
  assign extWordReq = (state_reg == ST_SECOND);

  wire take = clkEn & instrValid;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_FIRST:  if (take && decTwo) state_next = ST_SECOND;
      ST_SECOND: if (take) state_next = ST_FIRST;
      default:   state_next = ST_FIRST;
    endcase
  end

  // ****************************************
  // Sequential: state and held first word
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_FIRST;
      held_reg   <= 16'h0000;
      heldOp_reg <= `MCD_OP_NONE;
    end else if (clkEn) begin
      state_reg <= state_next;
      if (take && state_reg == ST_FIRST && decTwo) begin
        held_reg   <= instrWord;
        heldOp_reg <= decOp;
      end
    end
  end

  // ****************************************
  // Sequential: decoded outputs
  // ****************************************
  // Outputs are registered so execution units see stable fields for a full cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opValid           <= 1'b0;
      opCode            <= `MCD_OP_NONE;
      unrecognised      <= 1'b0;
      indirectMode      <= 1'b0;
      dataAddr          <= 7'h00;
      auxRegSel         <= 3'h0;
      immValue          <= 16'h0000;
      twoWordOp         <= 1'b0;
      clearSum          <= 1'b0;
      clearProduct      <= 1'b0;
      productShiftField <= 2'h0;
      ctrlBitSel        <= 4'h0;
      ctrlBitValue      <= 1'b0;
      statusWordOne     <= 1'b0;
      useBlockMovePtr   <= 1'b0;
      dataMove          <= 1'b0;
      lowPowerWait      <= 1'b0;
    end else if (clkEn) begin
      opValid      <= 1'b0;
      unrecognised <= 1'b0;
      clearSum     <= 1'b0;
      clearProduct <= 1'b0;
      lowPowerWait <= 1'b0;
      if (take && state_reg == ST_SECOND) begin
        // Second word: emit the held op with the captured operand
        opValid      <= 1'b1;
        opCode       <= heldOp_reg;
        twoWordOp    <= 1'b1;
        immValue     <= instrWord;
        indirectMode <= held_reg[`MCD_MODE_BIT];
        dataAddr     <= held_reg[6:0];
        auxRegSel    <= held_reg[2:0];
        dataMove     <= (heldOp_reg == `MCD_OP_MUL_ACC_SHIFT);
        clearSum     <= (heldOp_reg == `MCD_OP_CLEAR_REPEAT);
        clearProduct <= (heldOp_reg == `MCD_OP_CLEAR_REPEAT);
        useBlockMovePtr <= 1'b0;
      end else if (take && !decTwo) begin
        // Unrecognised words raise the flag only; no action strobe
        opValid      <= (decOp != `MCD_OP_NONE);
        unrecognised <= (decOp == `MCD_OP_NONE);
        opCode       <= decOp;
        twoWordOp    <= 1'b0;
        indirectMode <= instrWord[`MCD_MODE_BIT];
        dataAddr     <= instrWord[6:0];
        auxRegSel    <= instrWord[2:0];
        // Short immediates: 13 bits for multiply, 8 bits for repeat
        if (decOp == `MCD_OP_MUL_SHORT)
          immValue <= {3'h0, instrWord[12:0]};
        else
          immValue <= {8'h00, instrWord[7:0]};
        if (decOp == `MCD_OP_SET_SHIFT)
          productShiftField <= instrWord[1:0];
        ctrlBitSel      <= instrWord[3:0];
        ctrlBitValue    <= instrWord[0];
        statusWordOne   <= instrWord[8];
        useBlockMovePtr <= (decOp == `MCD_OP_MUL_ACC_PTR) |
                           (decOp == `MCD_OP_MUL_ACC_PTRMV);
        dataMove        <= (decOp == `MCD_OP_MUL_ACC_PTRMV) |
                           (decOp == `MCD_OP_LOAD_MULT_MV);
        clearProduct    <= (decOp == `MCD_OP_ZERO_PRODUCT);
        lowPowerWait    <= (decOp == `MCD_OP_LOW_POWER);
      end
    end
  end

endmodule // mcd_decoder

`default_nettype wire

// ==== verilog/mcd_map.vh ====
// Opcode patterns, field positions and decode codes for the multiply/control decoder
`ifndef MCD_MAP_VH
`define MCD_MAP_VH

// ****************************************
// Fixed whole-word opcodes
// ****************************************
`define MCD_W_ADD_PRODUCT    16'hbe04
`define MCD_W_PRODUCT_TO_SUM 16'hbe03
`define MCD_W_SUB_PRODUCT    16'hbe05
`define MCD_W_ZERO_PRODUCT   16'hbe58
`define MCD_W_MUL_LONG       16'hbe80
`define MCD_W_CLEAR_REPEAT   16'hbec5
`define MCD_W_LOW_POWER      16'hbe23
`define MCD_W_LOAD_MULT      16'h73

// ****************************************
// Upper-byte opcodes (low byte is IAAA AAAA or IIII IIII)
// ****************************************
`define MCD_B_LOAD_HIGH_PROD 8'h75
`define MCD_B_LOAD_MULT_ACC  8'h70
`define MCD_B_LOAD_MULT_MOVE 8'h72
`define MCD_B_LOAD_MULT_PROD 8'h71
`define MCD_B_LOAD_MULT_SUB  8'h74
`define MCD_B_MUL_ACC        8'ha2
`define MCD_B_MUL_ACC_SHIFT  8'ha3
`define MCD_B_MUL_ACC_PTR    8'haa
`define MCD_B_MUL_ACC_PTR_MV 8'hab
`define MCD_B_MULTIPLY_ADD   8'h50
`define MCD_B_MULTIPLY_SUB   8'h51
`define MCD_B_STORE_HIGH     8'h8d
`define MCD_B_STORE_LOW      8'h8c
`define MCD_B_SQUARE_ADD     8'h52
`define MCD_B_SQUARE_SUB     8'h53
`define MCD_B_LOAD_ST0       8'h0e
`define MCD_B_LOAD_ST1       8'h0f
`define MCD_B_STORE_ST0      8'h8e
`define MCD_B_STORE_ST1      8'h8f
`define MCD_B_REPEAT         8'hbb

// ****************************************
// Prefixes with a field in the low bits
// ****************************************
`define MCD_P_SHIFT_MODE     14'h2fc0
`define MCD_P_CTRL_BIT       12'hbe4
`define MCD_P_MUL_SHORT      3'h6

// ****************************************
// Decoded operation codes (op output)
// ****************************************
`define MCD_OP_NONE          5'h00
`define MCD_OP_ADD_PRODUCT   5'h01
`define MCD_OP_LOAD_HIGH     5'h02
`define MCD_OP_LOAD_MULT_ACC 5'h03
`define MCD_OP_LOAD_MULT_MV  5'h04
`define MCD_OP_LOAD_MULT_PRD 5'h05
`define MCD_OP_LOAD_MULT_SUB 5'h06
`define MCD_OP_MUL_ACC       5'h07
`define MCD_OP_MUL_ACC_SHIFT 5'h08
`define MCD_OP_MUL_ACC_PTR   5'h09
`define MCD_OP_MUL_ACC_PTRMV 5'h0a
`define MCD_OP_MUL_SHORT     5'h0b
`define MCD_OP_MUL_LONG      5'h0c
`define MCD_OP_MULTIPLY_ADD  5'h0d
`define MCD_OP_MULTIPLY_SUB  5'h0e
`define MCD_OP_PRODUCT_SUM   5'h0f
`define MCD_OP_SUB_PRODUCT   5'h10
`define MCD_OP_STORE_HIGH    5'h11
`define MCD_OP_STORE_LOW     5'h12
`define MCD_OP_SET_SHIFT     5'h13
`define MCD_OP_SQUARE_ADD    5'h14
`define MCD_OP_SQUARE_SUB    5'h15
`define MCD_OP_ZERO_PRODUCT  5'h16
`define MCD_OP_CLEAR_CTRL    5'h17
`define MCD_OP_SET_CTRL      5'h18
`define MCD_OP_LOAD_STATUS   5'h19
`define MCD_OP_STORE_STATUS  5'h1a
`define MCD_OP_REPEAT        5'h1b
`define MCD_OP_CLEAR_REPEAT  5'h1c
`define MCD_OP_LOW_POWER     5'h1d

// ****************************************
// Field positions
// ****************************************
`define MCD_MODE_BIT         7
`define MCD_CTRL_SEL_W       3

`endif

// ==== bench/mcd_fetch_model.sv ====
// Instruction fetch stage model that feeds words to the decoder
`default_nettype none
module mcd_fetch_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        sendReq,
  input  wire logic [15:0] sendWord,
  input  wire logic        instrReady,
  output var  logic        instrValid = 1'b0,
  output var  logic [15:0] instrWord = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word held until taken; when idle the bus toggles so stale data never looks valid
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instrValid <= 1'b0;
      instrWord  <= 16'h0000;
    end else if (!instrValid || instrReady) begin
      instrValid <= sendReq;
      instrWord  <= sendReq ? sendWord : ~instrWord;
    end
  end
endmodule // mcd_fetch_model
`default_nettype wire

// ==== bench/mcd_decoder_monitor.sv ====
// Concurrent checks on the multiply/control decoder ports
`include "mcd_map.vh"
`default_nettype none
module mcd_decoder_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        instrValid,
  input wire logic [15:0] instrWord,
  input wire logic        extWordReq,
  input wire logic        opValid,
  input wire logic [4:0]  opCode,
  input wire logic        unrecognised,
  input wire logic        indirectMode,
  input wire logic [6:0]  dataAddr,
  input wire logic [15:0] immValue,
  input wire logic        twoWordOp,
  input wire logic        clearSum,
  input wire logic        clearProduct,
  input wire logic [1:0]  productShiftField,
  input wire logic        ctrlBitValue
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Operand words are split off so they are never taken for opcodes
  wire logic newWord  = instrValid && clkEn && !extWordReq;
  wire logic extTaken = instrValid && clkEn && extWordReq;
  sequence longMulWord;
    newWord && instrWord == `MCD_W_MUL_LONG;
  endsequence
  sequence clrRptWord;
    newWord && instrWord == `MCD_W_CLEAR_REPEAT;
  endsequence
  excl_pulse_a: assert property (!(opValid && unrecognised))
    else $error("op valid and unrecognised together");
  add_prod_a: assert property (newWord && instrWord == `MCD_W_ADD_PRODUCT
    |=> opValid && opCode == `MCD_OP_ADD_PRODUCT) else $error("add product decode");
  short_mul_a: assert property (newWord && instrWord[15:13] == 3'h6 |=> opValid
    && immValue == {3'h0, $past(instrWord[12:0])}) else $error("short multiply decode");
  ext_wait_a: assert property (longMulWord |=> extWordReq && !opValid)
    else $error("no operand request");
  long_mul_a: assert property (longMulWord ##1 extTaken |=> opValid && twoWordOp
    && immValue == $past(instrWord)) else $error("long multiply operand");
  clr_rpt_a: assert property (clrRptWord ##1 extTaken |=> clearSum && clearProduct)
    else $error("clear and repeat pulses");
  zero_prod_a: assert property (newWord && instrWord == `MCD_W_ZERO_PRODUCT
    |=> clearProduct && !clearSum) else $error("zero product pulse");
  shift_field_a: assert property (newWord && instrWord[15:2] == `MCD_P_SHIFT_MODE
    |=> productShiftField == $past(instrWord[1:0])) else $error("shift field copy");
  mode_bit_a: assert property (newWord && instrWord[15:8] == `MCD_B_LOAD_HIGH_PROD
    |=> indirectMode == $past(instrWord[7]) && dataAddr == $past(instrWord[6:0]))
    else $error("mode bit or address");
  ctrl_bit_a: assert property (newWord && instrWord[15:4] == `MCD_P_CTRL_BIT
    |=> ctrlBitValue == $past(instrWord[0])) else $error("control bit value");
endmodule // mcd_decoder_monitor
bind mcd_decoder mcd_decoder_monitor u_mon (.mclk, .rst_n, .clkEn, .instrValid, .instrWord,
  .extWordReq, .opValid, .opCode, .unrecognised, .indirectMode, .dataAddr, .immValue,
  .twoWordOp, .clearSum, .clearProduct, .productShiftField, .ctrlBitValue);
`default_nettype wire

// ==== bench/mcd_decoder_test.sv ====
// Self-checking bench for the multiply/control decoder
`default_nettype none
module mcd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clkEn = 1'b1;
  logic        sendReq = 1'b0;
  logic [15:0] sendWord = 16'h0000;
  wire logic   instrValid, instrReady, extWordReq, opValid, unrecognised, indirectMode;
  wire logic   twoWordOp, clearSum, clearProduct, ctrlBitValue, statusWordOne;
  wire logic   useBlockMovePtr, dataMove, lowPowerWait;
  wire logic [15:0] instrWord, immValue;
  wire logic [4:0]  opCode;
  wire logic [6:0]  dataAddr;
  wire logic [1:0]  productShiftField;
  wire logic [2:0]  auxRegSel;
  wire logic [3:0]  ctrlBitSel;
  int          n_mismatch = 0;
  int          n_tests = 0;
  // Each entry is {expected op code, word}; op code 00 means refused by this group
  logic [20:0] oneTbl [30] = '{21'h01be04, 21'h027585, 21'h037001, 21'h047202, 21'h057103,
    21'h067404, 21'h09aa05, 21'h0aab06, 21'h0bdfff, 21'h0d5007, 21'h0e5108, 21'h0fbe03,
    21'h10be05, 21'h118d09, 21'h128c0a, 21'h13bf02, 21'h14520b, 21'h15530c, 21'h16be58,
    21'h17be46, 21'h18be47, 21'h190e0d, 21'h190f0e, 21'h1a8e0f, 21'h1a8f10, 21'h1bbb11,
    21'h1dbe23, 21'h007300, 21'h005400, 21'h00be22};
  logic [20:0] twoTbl [4] = '{21'h07a281, 21'h08a302, 21'h0cbe80, 21'h1cbec5};
  always #2 mclk = ~mclk;
  mcd_fetch_model u_fetch (.mclk, .rst_n, .sendReq, .sendWord, .instrReady, .instrValid,
    .instrWord);
  mcd_decoder DUT (.mclk, .rst_n, .clkEn, .instrValid, .instrWord, .instrReady, .extWordReq,
    .opValid, .opCode, .unrecognised, .indirectMode, .dataAddr, .auxRegSel, .immValue,
    .twoWordOp, .clearSum, .clearProduct, .productShiftField, .ctrlBitSel, .ctrlBitValue,
    .statusWordOne, .useBlockMovePtr, .dataMove, .lowPowerWait);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic issue(input logic [15:0] w);
    @(posedge mclk);
    sendReq  <= 1'b1;
    sendWord <= w;
  endtask
  // Stop feeding, then look 1 ns after the edge at which the word is taken
  task automatic decode(input logic [15:0] w);
    issue(w);
    @(posedge mclk);
    sendReq <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_one_word();
    for (int i = 0; i < 30; i++) begin
      decode(oneTbl[i][15:0]);
      check("valid", 16'({opValid, unrecognised}), oneTbl[i][20:16] != 0 ? 16'h2 : 16'h1);
      if (oneTbl[i][20:16] != 0) check("op", 16'(opCode), 16'(oneTbl[i][20:16]));
    end
  endtask
  task automatic test_fields();
    decode(16'h75a5);
    check("mode", 16'({indirectMode, dataAddr}), 16'h00a5);
    check("aux", 16'(auxRegSel), 16'h0005);
    decode(16'hbe4d);
    check("ctrlsel", 16'(ctrlBitSel), 16'h000d);
    decode(16'hbf03);
    decode(16'hbe04);
    check("shift", 16'(productShiftField), 16'h0003);
    decode(16'hdfff);
    check("imm", immValue, 16'h1fff);
    decode(16'hbb11);
    check("count", immValue, 16'h0011);
    decode(16'h0f0e);
    check("st1", 16'(statusWordOne), 16'h1);
    decode(16'hbe47);
    check("setbit", 16'(ctrlBitValue), 16'h1);
    decode(16'hbe23);
    check("wait", 16'(lowPowerWait), 16'h1);
    decode(16'hab06);
    check("ptr", 16'({useBlockMovePtr, dataMove}), 16'h3);
    decode(16'h7202);
    check("move", 16'(dataMove), 16'h1);
  endtask
  // Operand is itself an opcode word, so it must not be decoded
  task automatic test_two_word();
    for (int i = 0; i < 4; i++) begin
      issue(twoTbl[i][15:0]);
      issue(16'hbe04);
      @(posedge mclk);
      sendReq <= 1'b0;
      #1;
      check("req", 16'({extWordReq, opValid}), 16'h2);
      @(posedge mclk);
      #1;
      check("op2", 16'({opValid, twoWordOp, opCode}), 16'(twoTbl[i][20:16]) | 16'h60);
      check("opnd", immValue, 16'hbe04);
      if (i == 3) check("clr", 16'({clearSum, clearProduct}), 16'h3);
    end
  endtask
  // Enable low must freeze the take; the word waits on the bus until it rises
  task automatic test_freeze();
    @(posedge mclk);
    clkEn    <= 1'b0;
    sendReq  <= 1'b1;
    sendWord <= 16'hbe58;
    @(posedge mclk);
    sendReq <= 1'b0;
    @(posedge mclk);
    #1;
    check("frozen", 16'({opValid, clearProduct}), 16'h0);
    @(posedge mclk);
    clkEn <= 1'b1;
    @(posedge mclk);
    #1;
    check("thawed", 16'({opValid, clearProduct}), 16'h3);
  endtask
  // Reset in the middle of a two-word op must drop the pending operand wait
  task automatic test_reset();
    issue(16'hbe80);
    @(posedge mclk);
    sendReq <= 1'b0;
    @(posedge mclk);
    #1;
    check("pending", 16'(extWordReq), 16'h1);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    check("rstreq", 16'(extWordReq), 16'h0);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    decode(16'hbe04);
    check("afterrst", 16'({opValid, opCode}), 16'h21);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    test_one_word();
    test_fields();
    test_two_word();
    test_freeze();
    test_reset();
    finish_test();
  end
endmodule // mcd_decoder_test
`default_nettype wire
